// file: bench/obk_compositor_chk.sv
// port assertions for the overlay compositor
`timescale 1ns/100ps
module obk_compositor_chk import obk_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic pix_valid_i,
  input wire logic pix_ready_o,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [23:0] out_rgb_o,
  input wire logic [31:0] s0_lin_addr_i,
  input wire logic [31:0] s1_lin_addr_i,
  input wire logic [31:0] s2_lin_addr_i,
  input wire logic [31:0] s0_addr_o,
  input wire logic [31:0] s1_addr_o,
  input wire logic [31:0] s2_addr_o
);
  // ----
  // shadow of the control word
  // ----
  wire rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  wire rd_ctrl = rd_take && haddr_i[ADDR_MSB:ADDR_LSB] == IDX_CTRL;
  logic wr_ctrl_ff;
  logic [31:0] ctrl_ff;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ctrl_ff <= 1'b0;
      ctrl_ff <= CTRL_RST;
    end else begin
      wr_ctrl_ff <= hsel_i && hready_i && hwrite_i &&
        htrans_i[HTRANS_NSEQ_BIT] && haddr_i[ADDR_MSB:ADDR_LSB] == IDX_CTRL;
      if (wr_ctrl_ff) begin
        ctrl_ff <= hwdata_i;
      end
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence seq_take_empty;
    pix_valid_i && pix_ready_o && !out_valid_o;
  endsequence
  sequence seq_sink_on;
    out_ready_i [*3];
  endsequence
  a_resp_okay: assert property (hresp_o == HRESP_OKAY)
    else $error("response not okay");
  a_ready_high: assert property (hreadyout_o)
    else $error("wait state inserted");
  a_rdata_idle: assert property (!$past(rd_take) |-> hrdata_o == 32'h0)
    else $error("read data outside data phase");
  a_ctrl_read: assert property ($past(rd_ctrl) |-> hrdata_o == ctrl_ff)
    else $error("control read mismatch");
  a_pipe_latency: assert property (
    seq_take_empty ##1 seq_sink_on |=> out_valid_o)
    else $error("pixel late");
  a_out_hold: assert property (
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_rgb_o))
    else $error("output dropped while stalled");
  a_s2_linear: assert property (
    $past(rst_n_i) |-> s2_addr_o == $past(s2_lin_addr_i))
    else $error("third surface address changed");
  a_s0_pass: assert property (
    $past(rst_n_i) && !$past(ctrl_ff[F_TILE0])
    |-> s0_addr_o == $past(s0_lin_addr_i))
    else $error("surface 0 linear address altered");
  a_s1_pass: assert property (
    $past(rst_n_i) && !$past(ctrl_ff[F_TILE1])
    |-> s1_addr_o == $past(s1_lin_addr_i))
    else $error("surface 1 linear address altered");
endmodule // obk_compositor_chk

bind obk_compositor obk_compositor_chk chk (
  .clock_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
  .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
  .pix_valid_i, .pix_ready_o, .out_valid_o, .out_ready_i, .out_rgb_o,
  .s0_lin_addr_i, .s1_lin_addr_i, .s2_lin_addr_i,
  .s0_addr_o, .s1_addr_o, .s2_addr_o
);

// file: bench/obk_sink.sv
// display pipe stand-in that takes pixels promptly, slowly or never
`timescale 1ns/100ps
module obk_sink (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [1:0] mode_i,
  output logic ready_o
);
  logic [1:0] cnt_ff;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 2'h0;
      ready_o <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      // 0 every cycle, 1 one cycle in four, else stalled
      case (mode_i)
        2'h0: ready_o <= 1'b1;
        2'h1: ready_o <= cnt_ff == 2'h3;
        default: ready_o <= 1'b0;
      endcase
    end
  end
endmodule // obk_sink

// file: bench/overlay_blend_key_tiling_tb.sv
// self-checking bench for the overlay compositor
`timescale 1ns/100ps
module overlay_blend_key_tiling_tb import obk_pkg::*; ;
  logic clock_i, rst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic pix_valid_i, pix_ready_o, out_valid_o, out_ready_i;
  logic [1:0] htrans_i, mode;
  logic [2:0] hsize_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, s0_pix_i, s1_p00_i;
  logic [31:0] s1_p01_i, s1_p10_i, s1_p11_i, s2_pix_i, ctrl, alpha, sc;
  logic [31:0] s0_lin_addr_i, s1_lin_addr_i, s2_lin_addr_i;
  logic [31:0] s0_addr_o, s1_addr_o, s2_addr_o;
  logic [15:0] pix_x_i, pix_y_i;
  logic [23:0] out_rgb_o;
  logic [23:0] q[$];
  logic refused;
  int errors, checks_done;
  wire hready_i;
  assign hready_i = hreadyout_o;
  logic [31:0] t0[4] = '{32'h0010_80f0, 32'h55ff_007f, 32'h0020_4060,
                         32'haa01_fe33};
  logic [31:0] t1[4] = '{32'h00ff_ffff, 32'hff12_3456, 32'h80c0_8040,
                         32'h3c00_ff80};
  logic [31:0] t2[4] = '{32'hff0a_0b0c, 32'h00ff_ffff, 32'h7f33_6699,
                         32'hc880_8080};
  int m[4] = '{0, 'h60, 'h180, 'h8};
  obk_compositor uut (
    .clock_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
    .pix_valid_i, .pix_ready_o, .s0_pix_i, .s1_p00_i, .s1_p01_i,
    .s1_p10_i, .s1_p11_i, .s2_pix_i, .pix_x_i, .pix_y_i, .out_valid_o,
    .out_ready_i, .out_rgb_o, .s0_lin_addr_i, .s1_lin_addr_i,
    .s2_lin_addr_i, .s0_addr_o, .s1_addr_o, .s2_addr_o
  );
  obk_sink sink (.clock_i, .rst_n_i, .mode_i(mode), .ready_o(out_ready_i));
  // ----
  // reference arithmetic
  // ----
  function automatic logic [7:0] d255(input logic [15:0] x);
    logic [16:0] y;
    y = x + 17'h1 + (x >> 8);
    return y[15:8];
  endfunction
  function automatic logic [7:0] ch(input logic [7:0] lo, up, a,
                                    input logic pm);
    logic [8:0] s;
    s = d255(lo * (8'hff - a)) + (pm ? up : d255(up * a));
    return s[8] ? 8'hff : s[7:0];
  endfunction
  function automatic logic [31:0] lerp(input logic [31:0] a, b,
                                       input logic [7:0] f);
    logic [16:0] t;
    for (int i = 0; i < 32; i += 8) begin
      t = a[i+:8] * (9'h100 - f) + b[i+:8] * f;
      lerp[i+:8] = t[15:8];
    end
  endfunction
  function automatic logic [31:0] swp(input logic [31:0] p);
    return ctrl[F_SWAP_RB] ? {p[31:24], p[7:0], p[15:8], p[23:16]} : p;
  endfunction
  function automatic logic [23:0] blend(input logic [31:0] p0, p1, p2,
                                        input logic key);
    logic [7:0] a1, a2;
    a1 = ctrl[F_CONST_A1] ? alpha[7:0] : p1[31:24];
    a2 = ctrl[F_CONST_A2] ? alpha[15:8] : p2[31:24];
    if (key) begin
      a1 = 8'h0;
      p1 = 32'h0;
    end
    for (int i = 0; i < 24; i += 8) begin
      blend[i+:8] = ch(ch(p0[i+:8], p1[i+:8], a1, ctrl[F_PREMUL1]),
                       p2[i+:8], a2, ctrl[F_PREMUL2]);
    end
  endfunction
  function automatic logic [31:0] tile(input logic [31:0] l, input int s);
    int lw, lh, x, y;
    logic [31:0] i;
    lw = 7 - s;
    lh = 5 + s;
    x = (l >> 2) & 1023;
    y = l >> 12;
    i = (((y >> lh) << (10 - lw)) + (x >> lw)) << (lw + lh);
    i = i | ((y % (1 << lh)) << lw) | (x % (1 << lw));
    return {i[29:0], l[1:0]};
  endfunction
  // ----
  // drivers and compare
  // ----
  task automatic cmp(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    do begin
      @(posedge clock_i);
    end while (hready_i !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do begin
      @(posedge clock_i);
    end while (hready_i !== 1'b1);
    r = hrdata_o;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a, e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    cmp(r, e);
  endtask
  task automatic px(input logic [31:0] p0, a, b, c, d, p2,
                    input logic [15:0] x, input logic key);
    int n;
    logic [31:0] e;
    e = a;
    if (ctrl[F_SCALE_EN]) begin
      e = lerp(lerp(a, b, sc[7:0]), lerp(c, d, sc[7:0]), sc[15:8]);
    end
    q.push_back(blend(swp(p0), swp(e), swp(p2), key));
    pix_valid_i <= 1'b1;
    s0_pix_i <= p0;
    s1_p00_i <= a;
    s1_p01_i <= b;
    s1_p10_i <= c;
    s1_p11_i <= d;
    s2_pix_i <= p2;
    pix_x_i <= x;
    pix_y_i <= x;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pix_ready_o !== 1'b1 && n < 100);
  endtask
  task automatic drain;
    int n;
    pix_valid_i <= 1'b0;
    n = 0;
    while (q.size() != 0 && n < 2000) begin
      @(posedge clock_i);
      n++;
    end
    cmp(q.size(), 0);
  endtask
  task automatic ad(input logic [31:0] l, e0, e1);
    s0_lin_addr_i <= l;
    s1_lin_addr_i <= l;
    s2_lin_addr_i <= l;
    @(posedge clock_i);
    @(posedge clock_i);
    cmp(s0_addr_o, e0);
    cmp(s1_addr_o, e1);
    cmp(s2_addr_o, l);
  endtask
  task complete_run;
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    if (rst_n_i && pix_valid_i && pix_ready_o === 1'b0) begin
      refused = 1'b1;
    end
    if (rst_n_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      cmp({8'h0, out_rgb_o}, {8'h0, q.pop_front()});
    end
  end
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  initial begin
    #500000;
    errors++;
    complete_run();
  end
  // ----
  // scenarios
  // ----
  initial begin
    {rst_n_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
    {pix_valid_i, s0_pix_i, s1_p00_i, s1_p01_i, s1_p10_i} = '0;
    {s1_p11_i, s2_pix_i, pix_x_i, pix_y_i, mode, refused} = '0;
    {s0_lin_addr_i, s1_lin_addr_i, s2_lin_addr_i} = '0;
    hsize_i = 3'h2;
    ctrl = CTRL_RST;
    alpha = 32'h40c0;
    sc = 32'h4020;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    rd(OFS_CTRL, CTRL_RST);
    rd(OFS_STATUS, 32'h0000_0001);
    rd(32'h20, 32'h0);
    wr(32'h4, alpha);
    rd(32'h4, alpha);
    for (int k = 0; k < 4; k++) begin
      ctrl = CTRL_RST | m[k];
      mode <= {1'b0, k[0]};
      wr(OFS_CTRL, ctrl);
      for (int j = 0; j < 4; j++) begin
        px(t0[j], t1[j], 0, 0, 0, t2[j], 0, 0);
      end
      drain();
    end
    ctrl = CTRL_RST | 32'h7;
    wr(OFS_CTRL, ctrl);
    wr(32'hc, t0[0]);
    wr(32'h8, t1[1]);
    wr(32'h10, 32'h0064_000a);
    wr(32'h14, 32'h0064_000a);
    px(t0[0], t1[2], 0, 0, 0, t2[2], 50, 1);
    px(t0[2], t1[1], 0, 0, 0, t2[2], 50, 1);
    px(t0[2], t1[2], 0, 0, 0, t2[2], 9, 1);
    px(t0[2], t1[2], 0, 0, 0, t2[2], 100, 0);
    drain();
    ctrl = CTRL_RST | (32'h1 << F_SCALE_EN);
    wr(OFS_CTRL, ctrl);
    wr(32'h18, sc);
    px(t0[2], t1[2], t1[2], t1[3], t1[3], t2[2], 0, 0);
    px(t0[2], t1[2], t1[3], t1[2], t1[3], t2[2], 0, 0);
    drain();
    ctrl = CTRL_RST;
    wr(OFS_CTRL, ctrl);
    mode <= 2'h2;
    fork
      for (int j = 0; j < 8; j++) begin
        px(t0[j%4], t1[j%4], 0, 0, 0, t2[j%4], 0, 0);
      end
      begin
        repeat (40) @(posedge clock_i);
        cmp(refused, 1);
        mode <= 2'h0;
      end
    join
    drain();
    rd(OFS_STATUS, 32'h001e_0001);
    ad(32'h0003_a5c9, 32'h0003_a5c9, 32'h0003_a5c9);
    for (int s = 0; s < 3; s++) begin
      // only surface 0 is switched to tiled mode, for each of the three shapes
      ctrl = CTRL_RST | (32'h1 << F_TILE0) | (s << F_SHAPE_LO);
      wr(OFS_CTRL, ctrl);
      ad(32'h0003_a5c8 + s, tile(32'h0003_a5c8 + s, s), 32'h0003_a5c8 + s);
    end
    wr(OFS_CTRL, CTRL_RST | (32'h1 << F_TILE1));
    ad(32'h0007_1236, 32'h0007_1236, tile(32'h0007_1236, 0));
    complete_run();
  end
endmodule // overlay_blend_key_tiling_tb

// file: design/obk_compositor.sv
// three-surface overlay compositor with keying, scaling and tiling
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
// How it works
// - three surfaces enter: 0 primary, 1 video or 3d, 2 sub-picture
// - surface 0 blends with 1 first, that result then with 2
// - mid = c0 times (max minus a1) plus c1 times a1, per channel
// - out = mid times (max minus a2) plus c2 times a2, per channel
// - each blend alpha is per pixel or a per-surface constant
// - premultiplied colour is used as is, not scaled by alpha again
// - source, destination and window keying decide replaced pixels
// - destination key match keeps the surface 0 pixel through the first blend; surface 2 still blends over it
// - a formatter stage swaps, keys and times data before blending
// - surface 1 is scaled bilinearly in both directions
// - tiles of 128x32, 64x64 and 32x128 pixels are supported
// - tiled mode turns linear addresses into tiled ones, else passes
// - only surfaces 0 and 1 convert; surface 2 stays linear
module obk_compositor import obk_pkg::*; #(
  parameter int BUF_DEPTH = 2
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  input wire logic [31:0] s0_pix_i,
  input wire logic [31:0] s1_p00_i,
  input wire logic [31:0] s1_p01_i,
  input wire logic [31:0] s1_p10_i,
  input wire logic [31:0] s1_p11_i,
  input wire logic [31:0] s2_pix_i,
  input wire logic [15:0] pix_x_i,
  input wire logic [15:0] pix_y_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [23:0] out_rgb_o,
  input wire logic [31:0] s0_lin_addr_i,
  input wire logic [31:0] s1_lin_addr_i,
  input wire logic [31:0] s2_lin_addr_i,
  output logic [31:0] s0_addr_o,
  output logic [31:0] s1_addr_o,
  output logic [31:0] s2_addr_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] alpha;
    logic [31:0] skey;
    logic [31:0] dkey;
    logic [31:0] winx;
    logic [31:0] winy;
    logic [31:0] scale;
    logic [15:0] opix_cnt;
    logic wr_pend;
    logic [4:0] wr_idx;
    logic [31:0] rdata;
    logic hready;
    logic hresp;
    logic in_rdy;
    logic v1;
    logic [23:0] c0_1;
    logic [23:0] c1_1;
    logic [23:0] c2_1;
    logic [7:0] a1_1;
    logic [7:0] a2_1;
    logic pm1_1;
    logic pm2_1;
    logic v2;
    logic [23:0] c01_2;
    logic [23:0] c2_2;
    logic [7:0] a2_2;
    logic pm2_2;
    logic v3;
    logic [23:0] res_3;
    logic bv0;
    logic bv1;
    logic [23:0] b0;
    logic [23:0] b1;
    logic [31:0] addr0;
    logic [31:0] addr1;
    logic [31:0] addr2;
  } obk_state_s;

  localparam obk_state_s ST_RST = '{
    ctrl: CTRL_RST, hready: 1'b1, hresp: HRESP_OKAY, default: '0};

  obk_state_s st_ff;
  obk_state_s nxt_st;

  // ----------------------------------------------------------------
  // arithmetic helpers
  // ----------------------------------------------------------------
  // division by 255 rounded down, exact for products of two bytes
  function automatic logic [7:0] div_max(input logic [15:0] x);
    logic [16:0] t;
    t = {1'b0, x} + 17'h00001 + {9'h000, x[15:8]};
    return t[15:8];
  endfunction

  function automatic logic [7:0] lerp8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic [7:0] f);
    logic [16:0] t;
    t = {1'b0, a} * (17'h00100 - {9'h000, f}) + {9'h000, b} * {9'h000, f};
    return t[15:8];
  endfunction

  function automatic logic [31:0] lerp32(input logic [31:0] a,
                                         input logic [31:0] b,
                                         input logic [7:0] f);
    logic [31:0] r;
    r = '0;
    for (int k = 0; k < 4; k++) begin
      r[k*8 +: 8] = lerp8(a[k*8 +: 8], b[k*8 +: 8], f);
    end
    return r;
  endfunction

  // lower times (max - a) plus upper times a, or upper as is if premult
  function automatic logic [23:0] blend(input logic [23:0] lo,
                                        input logic [23:0] up,
                                        input logic [7:0] a,
                                        input logic pm);
    logic [23:0] r;
    logic [8:0] s;
    logic [7:0] ut;
    r = '0;
    for (int k = 0; k < 3; k++) begin
      ut = pm ? up[k*8 +: 8] : div_max(up[k*8 +: 8] * a);
      s = {1'b0, div_max(lo[k*8 +: 8] * (ALPHA_MAX - a))} + {1'b0, ut};
      r[k*8 +: 8] = s[8] ? ALPHA_MAX : s[7:0];
    end
    return r;
  endfunction

  // linear byte address to tiled byte address for a pow2 pitch
  function automatic logic [31:0] tile_addr(input logic [31:0] lin,
                                            input logic [1:0] shape,
                                            input logic [3:0] plog);
    logic [31:0] pix;
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] idx;
    logic [3:0] lw;
    logic [3:0] lh;
    pix = {2'b00, lin[31:2]};
    case (shape)
      OBK_TILE_128X32: begin
        lw = LW_128;
        lh = LW_32;
      end
      OBK_TILE_32X128: begin
        lw = LW_32;
        lh = LW_128;
      end
      default: begin
        lw = LW_64;
        lh = LW_64;
      end
    endcase
    x = pix & ((32'h1 << plog) - 32'h1);
    y = pix >> plog;
    idx = ((((y >> lh) << (plog - lw)) + (x >> lw)) << (lw + lh))
          | ((y & ((32'h1 << lh) - 32'h1)) << lw)
          | (x & ((32'h1 << lw) - 32'h1));
    return {idx[29:0], lin[1:0]};
  endfunction

  // ----------------------------------------------------------------
  // address converters, one per surface
  // ----------------------------------------------------------------
  logic [31:0] lin_addr [NSURF];
  logic [31:0] conv_addr [NSURF];
  logic [NSURF-1:0] tile_en;

  assign lin_addr[0] = s0_lin_addr_i;
  assign lin_addr[1] = s1_lin_addr_i;
  assign lin_addr[2] = s2_lin_addr_i;
  assign tile_en = {1'b0, st_ff.ctrl[F_TILE1], st_ff.ctrl[F_TILE0]};

  for (genvar g = 0; g < NSURF; g++) begin : g_conv
    assign conv_addr[g] = tile_en[g]
        ? tile_addr(lin_addr[g], st_ff.ctrl[F_SHAPE_LO +: 2],
                    st_ff.ctrl[F_PITCH_LO +: 4])
        : lin_addr[g];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic adv;
    logic take;
    logic pop;
    logic [31:0] p1;
    logic [31:0] s0c;
    logic [31:0] s2c;
    logic [7:0] a1;
    logic [7:0] a2;
    logic keyed;
    logic in_win;
    logic [1:0] cnt;
    adv = 1'b0;
    take = 1'b0;
    pop = 1'b0;
    p1 = '0;
    s0c = '0;
    s2c = '0;
    a1 = '0;
    a2 = '0;
    keyed = 1'b0;
    in_win = 1'b0;
    cnt = '0;
    nxt_st = st_ff;

    // bus write data phase, then address phase capture
    if (st_ff.wr_pend) begin
      case (st_ff.wr_idx)
        IDX_CTRL: nxt_st.ctrl = hwdata_i;
        IDX_ALPHA: nxt_st.alpha = hwdata_i;
        IDX_SKEY: nxt_st.skey = hwdata_i;
        IDX_DKEY: nxt_st.dkey = hwdata_i;
        IDX_WINX: nxt_st.winx = hwdata_i;
        IDX_WINY: nxt_st.winy = hwdata_i;
        IDX_SCALE: nxt_st.scale = hwdata_i;
        default: ;
      endcase
    end
    nxt_st.wr_pend = 1'b0;
    nxt_st.rdata = '0;
    if (hsel_i && hready_i && htrans_i[HTRANS_NSEQ_BIT]) begin
      nxt_st.wr_idx = haddr_i[ADDR_MSB:ADDR_LSB];
      nxt_st.wr_pend = hwrite_i && (haddr_i < OFS_STATUS);
      if (!hwrite_i && haddr_i <= OFS_STATUS) begin
        case (haddr_i[ADDR_MSB:ADDR_LSB])
          IDX_CTRL: nxt_st.rdata = nxt_st.ctrl;
          IDX_ALPHA: nxt_st.rdata = nxt_st.alpha;
          IDX_SKEY: nxt_st.rdata = nxt_st.skey;
          IDX_DKEY: nxt_st.rdata = nxt_st.dkey;
          IDX_WINX: nxt_st.rdata = nxt_st.winx;
          IDX_WINY: nxt_st.rdata = nxt_st.winy;
          IDX_SCALE: nxt_st.rdata = nxt_st.scale;
          IDX_STATUS: nxt_st.rdata = {st_ff.opix_cnt, 12'h000,
              st_ff.v3, st_ff.bv1, st_ff.bv0, st_ff.in_rdy};
          default: nxt_st.rdata = '0;
        endcase
      end
    end
    nxt_st.hready = 1'b1;
    nxt_st.hresp = HRESP_OKAY;

    // pipe moves unless stage 3 holds a pixel and the buffer is full
    adv = !(st_ff.v3 && st_ff.bv0 && st_ff.bv1);
    take = pix_valid_i && st_ff.in_rdy;
    pop = st_ff.bv0 && out_ready_i;

    // formatter: swap, scale, alpha select, keying
    s0c = st_ff.ctrl[F_SWAP_RB]
        ? {s0_pix_i[31:24], s0_pix_i[7:0], s0_pix_i[15:8], s0_pix_i[23:16]}
        : s0_pix_i;
    s2c = st_ff.ctrl[F_SWAP_RB]
        ? {s2_pix_i[31:24], s2_pix_i[7:0], s2_pix_i[15:8], s2_pix_i[23:16]}
        : s2_pix_i;
    p1 = st_ff.ctrl[F_SCALE_EN]
        ? lerp32(lerp32(s1_p00_i, s1_p01_i, st_ff.scale[7:0]),
                 lerp32(s1_p10_i, s1_p11_i, st_ff.scale[7:0]),
                 st_ff.scale[15:8])
        : s1_p00_i;
    if (st_ff.ctrl[F_SWAP_RB]) begin
      p1 = {p1[31:24], p1[7:0], p1[15:8], p1[23:16]};
    end
    a1 = st_ff.ctrl[F_CONST_A1] ? st_ff.alpha[7:0] : p1[31:24];
    a2 = st_ff.ctrl[F_CONST_A2] ? st_ff.alpha[15:8] : s2c[31:24];
    in_win = (pix_x_i >= st_ff.winx[15:0]) && (pix_x_i <= st_ff.winx[31:16])
          && (pix_y_i >= st_ff.winy[15:0]) && (pix_y_i <= st_ff.winy[31:16]);
    keyed = (st_ff.ctrl[F_DKEY_EN] && s0c[23:0] == st_ff.dkey[23:0])
         || (st_ff.ctrl[F_SKEY_EN] && p1[23:0] == st_ff.skey[23:0])
         || (st_ff.ctrl[F_WKEY_EN] && !in_win);

    if (adv) begin
      nxt_st.v1 = take;
      nxt_st.c0_1 = s0c[23:0];
      nxt_st.c1_1 = keyed ? 24'h000000 : p1[23:0];
      nxt_st.a1_1 = keyed ? 8'h00 : a1;
      nxt_st.pm1_1 = st_ff.ctrl[F_PREMUL1];
      nxt_st.c2_1 = s2c[23:0];
      nxt_st.a2_1 = a2;
      nxt_st.pm2_1 = st_ff.ctrl[F_PREMUL2];
      // first blend: surface 0 under surface 1
      nxt_st.v2 = st_ff.v1;
      nxt_st.c01_2 = blend(st_ff.c0_1, st_ff.c1_1, st_ff.a1_1,
                           st_ff.pm1_1);
      nxt_st.c2_2 = st_ff.c2_1;
      nxt_st.a2_2 = st_ff.a2_1;
      nxt_st.pm2_2 = st_ff.pm2_1;
      // second blend: that result under surface 2
      nxt_st.v3 = st_ff.v2;
      nxt_st.res_3 = blend(st_ff.c01_2, st_ff.c2_2, st_ff.a2_2,
                           st_ff.pm2_2);
    end

    // two-entry output buffer, head always in b0
    if (pop) begin
      nxt_st.bv0 = st_ff.bv1;
      nxt_st.b0 = st_ff.b1;
      nxt_st.bv1 = 1'b0;
    end
    if (adv && st_ff.v3) begin
      if (!nxt_st.bv0) begin
        nxt_st.bv0 = 1'b1;
        nxt_st.b0 = st_ff.res_3;
      end else begin
        nxt_st.bv1 = 1'b1;
        nxt_st.b1 = st_ff.res_3;
      end
    end
    if (pop) begin
      nxt_st.opix_cnt = st_ff.opix_cnt + 16'h0001;
    end
    cnt = {1'b0, nxt_st.bv0} + {1'b0, nxt_st.bv1};
    // ready says whether the pipe will move in the coming cycle
    nxt_st.in_rdy = !(nxt_st.v3 && cnt == 2'(BUF_DEPTH));

    nxt_st.addr0 = conv_addr[0];
    nxt_st.addr1 = conv_addr[1];
    nxt_st.addr2 = conv_addr[2];
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hrdata_o = st_ff.rdata;
  assign hreadyout_o = st_ff.hready;
  assign hresp_o = st_ff.hresp;
  assign pix_ready_o = st_ff.in_rdy;
  assign out_valid_o = st_ff.bv0;
  assign out_rgb_o = st_ff.b0;
  assign s0_addr_o = st_ff.addr0;
  assign s1_addr_o = st_ff.addr1;
  assign s2_addr_o = st_ff.addr2;

endmodule // obk_compositor

// file: inc/obk_pkg.sv
// constants shared by the overlay blend, key and tiling block
package obk_pkg;

  // ----------------------------------------------------------------
  // surfaces
  // ----------------------------------------------------------------
  localparam int NSURF = 3;
  localparam int NTILED = 2;
  localparam logic [7:0] ALPHA_MAX = 8'hff;

  // ----------------------------------------------------------------
  // register word indices and byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_ALPHA = 5'h01;
  localparam logic [4:0] IDX_SKEY = 5'h02;
  localparam logic [4:0] IDX_DKEY = 5'h03;
  localparam logic [4:0] IDX_WINX = 5'h04;
  localparam logic [4:0] IDX_WINY = 5'h05;
  localparam logic [4:0] IDX_SCALE = 5'h06;
  localparam logic [4:0] IDX_STATUS = 5'h07;
  localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS = 32'h0000_001c;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 6;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int F_DKEY_EN = 0;
  localparam int F_SKEY_EN = 1;
  localparam int F_WKEY_EN = 2;
  localparam int F_SWAP_RB = 3;
  localparam int F_SCALE_EN = 4;
  localparam int F_CONST_A1 = 5;
  localparam int F_CONST_A2 = 6;
  localparam int F_PREMUL1 = 7;
  localparam int F_PREMUL2 = 8;
  localparam int F_TILE0 = 9;
  localparam int F_TILE1 = 10;
  localparam int F_SHAPE_LO = 11;
  localparam int F_PITCH_LO = 16;
  localparam logic [31:0] CTRL_RST = 32'h000a_0000;

  // ----------------------------------------------------------------
  // tile shapes as log2 of width and height in pixels
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OBK_TILE_128X32 = 2'h0,
    OBK_TILE_64X64 = 2'h1,
    OBK_TILE_32X128 = 2'h2
  } obk_shape_e;
  localparam logic [3:0] LW_128 = 4'h7;
  localparam logic [3:0] LW_64 = 4'h6;
  localparam logic [3:0] LW_32 = 4'h5;

  // ----------------------------------------------------------------
  // ahb encodings
  // ----------------------------------------------------------------
  localparam int HTRANS_NSEQ_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

endpackage
